// ==== design/scr_pkg.sv ====
// package: register map and field layout of the spi control/status block
package scr_pkg;
  // ----------------------------------------
  // register indices (printed offsets, byte address = 4 * index)
  // ----------------------------------------
  localparam logic [3:0] CTL0_IDX = 4'h5;
  localparam logic [3:0] BUF1_IDX = 4'h6;
  localparam logic [3:0] BUF0_IDX = 4'h4;
  localparam logic [3:0] LINK_IDX = 4'h8;
  // ----------------------------------------
  // control register fields, link interrupt enable bit, reset values and responses
  // ----------------------------------------
  localparam int EN_BIT   = 0;
  localparam int MST_BIT  = 1;
  localparam int MFE_BIT  = 2;
  localparam int MF_BIT   = 3;
  localparam int WC_BIT   = 4;
  localparam int OV_BIT   = 5;
  localparam int TC_BIT   = 6;
  localparam int BSY_BIT  = 7;
  localparam int IE_BIT   = 8;
  localparam logic [7:0]  CTL_RST  = 8'h00;
  localparam logic [15:0] BUF_RST  = 16'h0000;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;
  // ----------------------------------------
  // transfer sequencer
  // ----------------------------------------
  localparam logic [4:0] XFER_BITS = 5'h10;
  typedef enum logic [1:0] {
    SCR_IDLE = 2'b00,
    SCR_SHIFT = 2'b01,
    SCR_DONE = 2'b11
  } scr_state_t;
endpackage

// ==== design/scr_regs.sv ====
// module: spi control/status registers and data buffers behind axi4-lite
`timescale 1ns/1ps
`default_nettype none
// How it works
// - module_enable 1 runs the port and baud clock, 0 stops both
// - master_select 1 means master, 0 means slave
// - master_select rises only while slave select is deasserted
// - in master mode, mode_fault_enable makes slave select a fault input
// - in slave mode slave select always selects the port
// - master with fault enable: falling slave select sets mode_fault_flag
// - mode_fault_flag is not set by slave select in slave mode
// - data write during a transfer sets write_collision_flag
// - busy blocks data writes, buffer kept; reads always allowed
// - second unread character sets overrun, newer data dropped
// - transfer end sets transfer_complete_flag
// - busy set at transfer start, cleared at its end
// - busy is hardware only; software writes to bit 7 ignored
// - software writing 1 to an event flag counts as an event
// - control register resets to 00h
// - data buffer one resets to 0000h
// - one address: write loads transmit, read returns receive
// - data buffers are sixteen bits wide
module scr_regs
  import scr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        ssel_b_pin,
  input  wire logic        xfer_start,
  input  wire logic        rx_valid,
  input  wire logic [15:0] rx_data,
  output logic             module_enable,
  output logic             baud_enable,
  output logic             master_select,
  output logic             slave_selected,
  output logic [15:0]      tx_data,
  output logic             tx_load,
  output logic             irq
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [3:0] reg_idx(input logic [31:0] a);
    reg_idx = (a[31:6] == 26'h0 && a[1:0] == 2'h0) ? a[5:2] : 4'hF;
  endfunction
  function automatic logic idx_ok(input logic [3:0] i);
    idx_ok = (i == CTL0_IDX) || (i == BUF0_IDX) || (i == BUF1_IDX)
          || (i == LINK_IDX);
  endfunction

  // ----------------------------------------
  // slave select pin synchroniser
  // ----------------------------------------
  logic [2:0] ss_sync_q;
  logic [2:0] ss_sync_d;
  logic       ss_q;
  logic       ss_d;
  always_comb begin
    ss_sync_d = {ss_sync_q[1:0], ssel_b_pin};
    ss_d = (ss_sync_q[2] == ss_sync_q[1]) ? ss_sync_q[2] : ss_q;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ss_sync_q <= 3'h7;
      ss_q      <= 1'b1;
    end else begin
      ss_sync_q <= ss_sync_d;
      ss_q      <= ss_d;
    end
  end
  // falling edge on the filtered level only, never on the raw stage
  wire ss_fall = ss_q && !ss_d;

  // ----------------------------------------
  // axi4-lite handshakes
  // ----------------------------------------
  logic        aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [3:0]  awi_q, awi_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;
  logic        ar_rdy_q, ar_rdy_d;
  logic [7:0]  ctl_q, ctl_d;
  logic        ie_q, ie_d;
  logic [15:0] tx0_q, tx0_d, tx1_q, tx1_d, rx_q, rx_d;
  logic        rx_full_q, rx_full_d;
  scr_state_t  st_q, st_d;
  logic [4:0]  cnt_q, cnt_d;
  logic        tl_q, tl_d, irq_q, irq_d;
  logic        awrdy_q, awrdy_d, wrdy_q, wrdy_d;
  logic        lst_q, lst_d;
  logic [15:0] txd_q, txd_d;

  wire wr_fire = aw_q && w_q && !bv_q;
  wire rd_fire = s_axi_arvalid && ar_rdy_q;
  wire busy    = ctl_q[BSY_BIT];
  wire is_buf  = (awi_q == BUF0_IDX) || (awi_q == BUF1_IDX);
  wire wr_buf  = wr_fire && is_buf;
  wire rd_buf  = rd_fire && ((reg_idx(s_axi_araddr) == BUF0_IDX)
                 || (reg_idx(s_axi_araddr) == BUF1_IDX));

  always_comb begin
    aw_d  = aw_q;
    awi_d = awi_q;
    w_d   = w_q;
    wd_d  = wd_q;
    bv_d  = bv_q;
    br_d  = br_q;
    // capture keys off the ready flop so both sides see one handshake
    if (s_axi_awvalid && awrdy_q) begin
      aw_d  = 1'b1;
      awi_d = reg_idx(s_axi_awaddr);
    end
    if (s_axi_wvalid && wrdy_q) begin
      w_d  = 1'b1;
      wd_d = s_axi_wdata;
    end
    if (wr_fire) begin
      aw_d = 1'b0;
      w_d  = 1'b0;
      bv_d = 1'b1;
      br_d = idx_ok(awi_q) ? RESP_OK : RESP_ERR;
    end
    if (bv_q && s_axi_bready)
      bv_d = 1'b0;
    awrdy_d = !aw_d;
    wrdy_d  = !w_d;
    ar_rdy_d = !rv_q && !rd_fire;
    rv_d = rv_q;
    rd_d = rd_q;
    rr_d = rr_q;
    if (rd_fire) begin
      rv_d = 1'b1;
      rr_d = idx_ok(reg_idx(s_axi_araddr)) ? RESP_OK : RESP_ERR;
      case (reg_idx(s_axi_araddr))
        CTL0_IDX: rd_d = {24'h0, ctl_q};
        BUF0_IDX: rd_d = {16'h0, rx_q};
        BUF1_IDX: rd_d = {16'h0, rx_q};
        LINK_IDX: rd_d = {23'h0, ie_q, 8'h00};
        default:  rd_d = 32'h0;
      endcase
    end else if (rv_q && s_axi_rready) begin
      rv_d = 1'b0;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_q     <= 1'b0;
      awi_q    <= 4'h0;
      w_q      <= 1'b0;
      wd_q     <= 32'h0;
      bv_q     <= 1'b0;
      br_q     <= 2'h0;
      ar_rdy_q <= 1'b0;
      rv_q     <= 1'b0;
      rd_q     <= 32'h0;
      rr_q     <= 2'h0;
      awrdy_q  <= 1'b0;
      wrdy_q   <= 1'b0;
    end else begin
      aw_q     <= aw_d;
      awi_q    <= awi_d;
      w_q      <= w_d;
      wd_q     <= wd_d;
      bv_q     <= bv_d;
      br_q     <= br_d;
      ar_rdy_q <= ar_rdy_d;
      rv_q     <= rv_d;
      rd_q     <= rd_d;
      rr_q     <= rr_d;
      awrdy_q  <= awrdy_d;
      wrdy_q   <= wrdy_d;
    end
  end
  assign s_axi_awready = awrdy_q;
  assign s_axi_wready  = wrdy_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_arready = ar_rdy_q;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = rr_q;

  // ----------------------------------------
  // control register, flags, buffers, sequencer
  // ----------------------------------------
  wire en   = ctl_q[EN_BIT];
  wire mst  = ctl_q[MST_BIT];
  wire ctlw = wr_fire && awi_q == CTL0_IDX;
  wire done = (st_q == SCR_DONE);
  always_comb begin
    ctl_d = ctl_q;
    ie_d  = ie_q;
    tx0_d = tx0_q;
    tx1_d = tx1_q;
    rx_d  = rx_q;
    rx_full_d = rx_full_q;
    st_d  = st_q;
    cnt_d = cnt_q;
    tl_d  = 1'b0;
    lst_d = lst_q;
    if (ctlw) begin
      ctl_d[EN_BIT]  = wd_q[EN_BIT];
      ctl_d[MFE_BIT] = wd_q[MFE_BIT];
      // rising master select allowed only with slave select high
      if (!wd_q[MST_BIT] || mst || ss_q)
        ctl_d[MST_BIT] = wd_q[MST_BIT];
      ctl_d[TC_BIT:MF_BIT] = wd_q[TC_BIT:MF_BIT];
    end
    if (wr_fire && awi_q == LINK_IDX)
      ie_d = wd_q[IE_BIT];
    if (wr_buf && busy) begin
      ctl_d[WC_BIT] = 1'b1;
    end else if (wr_buf) begin
      if (awi_q == BUF0_IDX) begin
        tx0_d = wd_q[15:0];
        lst_d = 1'b0;
      end else begin
        tx1_d = wd_q[15:0];
        lst_d = 1'b1;
      end
      tl_d = en;
    end
    if (mst && ctl_q[MFE_BIT] && ss_fall)
      ctl_d[MF_BIT] = 1'b1;
    if (rd_buf)
      rx_full_d = 1'b0;
    if (rx_valid && en) begin
      if (rx_full_q && !rd_buf) ctl_d[OV_BIT] = 1'b1;
      else begin
        rx_d = rx_data;
        rx_full_d = 1'b1;
      end
    end
    case (st_q)
      SCR_IDLE: if (en && xfer_start) begin
        st_d = SCR_SHIFT;
        cnt_d = XFER_BITS;
      end
      SCR_SHIFT: begin
        cnt_d = cnt_q - 5'h1;
        if (!en) st_d = SCR_IDLE;
        else if (cnt_q == 5'h1) st_d = SCR_DONE;
      end
      SCR_DONE: begin
        st_d = SCR_IDLE;
        ctl_d[TC_BIT] = 1'b1;
      end
      default: st_d = SCR_IDLE;
    endcase
    ctl_d[BSY_BIT] = (st_d == SCR_SHIFT);
    // next enable too, so the request never lags a fresh enable write
    irq_d = ie_d && (ctl_d[TC_BIT:MF_BIT] != 4'h0);
    // the buffer written last feeds the shifter
    txd_d = lst_d ? tx1_d : tx0_d;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_q <= CTL_RST;
      tx1_q <= BUF_RST;
      tx0_q <= BUF_RST;
      rx_q  <= BUF_RST;
      ie_q      <= 1'b0;
      rx_full_q <= 1'b0;
      st_q      <= SCR_IDLE;
      cnt_q     <= 5'h0;
      tl_q      <= 1'b0;
      irq_q     <= 1'b0;
      lst_q     <= 1'b0;
      txd_q     <= BUF_RST;
    end else begin
      ctl_q     <= ctl_d;
      tx1_q     <= tx1_d;
      tx0_q     <= tx0_d;
      rx_q      <= rx_d;
      ie_q      <= ie_d;
      rx_full_q <= rx_full_d;
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      tl_q      <= tl_d;
      irq_q     <= irq_d;
      lst_q     <= lst_d;
      txd_q     <= txd_d;
    end
  end
  assign module_enable = ctl_q[EN_BIT];
  assign baud_enable   = ctl_q[EN_BIT];
  assign master_select = ctl_q[MST_BIT];
  logic sel_q;
  logic sel_d;
  always_comb begin
    sel_d = !ctl_d[MST_BIT] && !ss_d;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_q <= 1'b0;
    end else begin
      sel_q <= sel_d;
    end
  end
  assign slave_selected = sel_q;
  assign tx_data = txd_q;
  assign tx_load = tl_q;
  assign irq     = irq_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  busy_block_a: assert property (@(posedge clk)
    disable iff (!rst_b) wr_buf && busy
    |=> ctl_q[WC_BIT] && $stable(tx0_q) && $stable(tx1_q))
    else $error("write during busy not blocked");
  mst_rise_a: assert property (@(posedge clk)
    disable iff (!rst_b) $rose(ctl_q[MST_BIT]) |-> $past(ss_q))
    else $error("master select rose while selected");
  fault_set_a: assert property (@(posedge clk)
    disable iff (!rst_b) mst && ctl_q[MFE_BIT] && ss_fall |=> ctl_q[MF_BIT])
    else $error("mode fault missed");
  done_flag_a: assert property (@(posedge clk)
    disable iff (!rst_b) done |=> ctl_q[TC_BIT] && !ctl_q[BSY_BIT])
    else $error("complete flag missing");
  busy_span_a: assert property (@(posedge clk)
    disable iff (!rst_b) st_q == SCR_IDLE && en && xfer_start
    |=> ctl_q[BSY_BIT][*8])
    else $error("busy not held");
  overrun_keep_a: assert property (@(posedge clk)
    disable iff (!rst_b) rx_valid && en && rx_full_q && !rd_buf
    |=> $stable(rx_q) && ctl_q[OV_BIT])
    else $error("overrun lost old data");
  irq_out_a: assert property (@(posedge clk)
    disable iff (!rst_b) ie_q && ctl_q[TC_BIT] |-> irq)
    else $error("interrupt not raised");
  enable_out_a: assert property (@(posedge clk)
    disable iff (!rst_b) !en && st_q == SCR_IDLE |=> st_q == SCR_IDLE)
    else $error("transfer ran while disabled");
  load_pulse_a: assert property (@(posedge clk)
    disable iff (!rst_b) wr_buf && !busy && en |=> tx_load)
    else $error("transmit load missing");
  cv_xfer: cover property (@(posedge clk) st_q == SCR_DONE);
  cv_coll: cover property (@(posedge clk) wr_buf && busy);
  cv_fault: cover property (@(posedge clk) $rose(ctl_q[MF_BIT]));
  cv_overrun: cover property (@(posedge clk) rx_valid && en && rx_full_q);
  cv_irq: cover property (@(posedge clk) $rose(irq));
endmodule
`default_nettype wire

// ==== verification/scr_link_model.sv ====
// partner model: far-side traffic of the spi control block
`timescale 1ns/1ps
`default_nettype none
module scr_link_model (
  input  wire logic   clk,
  output logic        ssel_b_pin,
  output logic        xfer_start,
  output logic        rx_valid,
  output logic [15:0] rx_data
);
  logic [15:0] nxt = 16'h0000;
  logic        pend = 1'b0;
  initial begin
    ssel_b_pin = 1'b1;
    xfer_start = 1'b0;
    rx_valid = 1'b0;
    rx_data = 16'h5A5A;
  end
  // idle data flips each cycle so a stale word never looks fresh
  always @(posedge clk) begin
    rx_valid <= pend;
    rx_data <= pend ? nxt : ~rx_data;
  end
  // pin filter needs a few cycles before a new level counts
  task automatic sel(input logic lvl);
    @(posedge clk);
    ssel_b_pin <= lvl;
    repeat (6) @(posedge clk);
  endtask
  task automatic xfer();
    @(posedge clk);
    xfer_start <= 1'b1;
    @(posedge clk);
    xfer_start <= 1'b0;
  endtask
  task automatic send(input logic [15:0] v);
    @(negedge clk);
    nxt = v;
    pend = 1'b1;
    @(negedge clk);
    pend = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// testbench: register-level checks of the spi control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR at %0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
  import scr_pkg::*;
  localparam logic [31:0] A_CTL = {26'h0, CTL0_IDX, 2'b00};
  localparam logic [31:0] A_BF1 = {26'h0, BUF1_IDX, 2'b00};
  localparam logic [31:0] A_BF0 = {26'h0, BUF0_IDX, 2'b00};
  localparam logic [31:0] A_IE = {26'h0, LINK_IDX, 2'b00};
  logic clk = 1'b0, rst_b = 1'b0;
  logic [31:0] awaddr, wdata, araddr, rdata, v1;
  logic [31:0] rs = 32'h0001_0A62;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic mod_en, baud_en, mst, slv_sel, tx_load, irq;
  logic [15:0] tx_data;
  wire logic ssel_b, xstart, rxv;
  wire logic [15:0] rxd;
  logic [33:0] expq[$];
  logic [33:0] e;
  int n_fail = 0, compares = 0, n_load = 0;
  scr_regs i_scr_regs (
    .clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ssel_b_pin(ssel_b), .xfer_start(xstart),
    .rx_valid(rxv), .rx_data(rxd), .module_enable(mod_en),
    .baud_enable(baud_en), .master_select(mst), .slave_selected(slv_sel),
    .tx_data(tx_data), .tx_load(tx_load), .irq(irq));
  scr_link_model i_scr_link_model (.clk(clk), .ssel_b_pin(ssel_b),
    .xfer_start(xstart), .rx_valid(rxv), .rx_data(rxd));
  always #2.5 clk = ~clk;
  // ----------------------------------------
  // bus master and result watcher
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic report_and_stop();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // sampling at the falling edge sees what the next rising edge takes
  task automatic bus(input logic w, input logic [31:0] a, v,
                     input logic [1:0] r);
    int n;
    logic ah, wh, bh;
    expq.push_back({r, w ? 32'h0 : v});
    rs = lfsr(rs);
    @(posedge clk);
    awaddr <= a;
    wstrb <= rs[3:0];
    araddr <= a;
    wdata <= v;
    awvalid <= w;
    wvalid <= w;
    bready <= w;
    arvalid <= !w;
    rready <= !w;
    bh = 1'b0;
    for (n = 0; n < 64 && !bh; n++) begin
      @(negedge clk);
      ah = (awvalid && awready) || (arvalid && arready);
      wh = wvalid && wready;
      bh = (bvalid && bready) || (rvalid && rready);
      @(posedge clk);
      awvalid <= awvalid & ~ah;
      arvalid <= arvalid & ~ah;
      wvalid <= wvalid & ~wh;
      bready <= bready & ~bh;
      rready <= rready & ~bh;
    end
    if (!bh) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  always @(negedge clk) begin
    if (tx_load) n_load++;
  end
  always @(negedge clk) begin
    if ((bvalid && bready) || (rvalid && rready)) begin
      e = expq.size() > 0 ? expq.pop_front() : 34'h3_FFFF_FFFF;
      if (bvalid) `CHK({bresp, 32'h0}, e)
      else `CHK({rresp, rdata}, e)
    end
  end
  initial begin
    awaddr <= 32'h0;
    wdata <= 32'h0;
    araddr <= 32'h0;
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b0;
    arvalid <= 1'b0;
    rready <= 1'b0;
    wstrb <= 4'h0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    bus(1'b0, A_CTL, 32'h0, RESP_OK);
    bus(1'b0, A_BF1, 32'h0, RESP_OK);
    bus(1'b0, 32'h3C, 32'h0, RESP_ERR);
    @(negedge clk);
    `CHK(tx_data, 16'h0000)
    i_scr_link_model.xfer();
    bus(1'b0, A_CTL, 32'h0, RESP_OK);
    i_scr_link_model.sel(1'b0);
    bus(1'b1, A_CTL, 32'h7, RESP_OK);
    bus(1'b0, A_CTL, 32'h5, RESP_OK);
    @(negedge clk);
    `CHK({mod_en, baud_en, mst, slv_sel}, 4'hD)
    i_scr_link_model.sel(1'b1);
    i_scr_link_model.sel(1'b0);
    bus(1'b0, A_CTL, 32'h5, RESP_OK);
    i_scr_link_model.sel(1'b1);
    bus(1'b1, A_CTL, 32'h87, RESP_OK);
    bus(1'b0, A_CTL, 32'h7, RESP_OK);
    @(negedge clk);
    `CHK({mst, slv_sel, irq}, 3'h4)
    i_scr_link_model.sel(1'b0);
    bus(1'b0, A_CTL, 32'hF, RESP_OK);
    bus(1'b1, A_IE, 32'h100, RESP_OK);
    @(negedge clk);
    `CHK(irq, 1'b1)
    bus(1'b1, A_CTL, 32'h7, RESP_OK);
    @(negedge clk);
    `CHK(irq, 1'b0)
    bus(1'b1, A_CTL, 32'h47, RESP_OK);
    @(negedge clk);
    `CHK(irq, 1'b1)
    bus(1'b1, A_CTL, 32'h3, RESP_OK);
    i_scr_link_model.sel(1'b1);
    i_scr_link_model.sel(1'b0);
    bus(1'b0, A_CTL, 32'h3, RESP_OK);
    bus(1'b1, A_CTL, 32'h7, RESP_OK);
    rs = lfsr(rs);
    v1 = {16'h0, rs[15:0]};
    bus(1'b1, A_BF1, v1, RESP_OK);
    @(negedge clk);
    `CHK(tx_data, v1[15:0])
    `CHK(n_load, 1)
    i_scr_link_model.xfer();
    bus(1'b0, A_CTL, 32'h87, RESP_OK);
    bus(1'b1, A_BF1, ~v1, RESP_OK);
    @(negedge clk);
    `CHK(tx_data, v1[15:0])
    `CHK(n_load, 1)
    // busy lasts sixteen cycles, so twenty leaves room for the done cycle
    repeat (20) @(posedge clk);
    bus(1'b0, A_CTL, 32'h57, RESP_OK);
    bus(1'b1, A_BF0, ~v1, RESP_OK);
    @(negedge clk);
    `CHK(tx_data, ~v1[15:0])
    `CHK(n_load, 2)
    bus(1'b1, A_CTL, 32'h7, RESP_OK);
    rs = lfsr(rs);
    i_scr_link_model.send(rs[15:0]);
    i_scr_link_model.send(~rs[15:0]);
    bus(1'b0, A_BF0, {16'h0, rs[15:0]}, RESP_OK);
    bus(1'b0, A_CTL, 32'h27, RESP_OK);
    report_and_stop();
  end
endmodule
`default_nettype wire
